// ### hw/xbi_pkg.sv
package xbi_pkg;

  // Machine cycle: six states of two phases, one oscillator period per mclk
  localparam int unsigned  TICKS_PER_CYCLE  = 12;
  localparam int unsigned  TICKS_PER_HALF   = 6;
  localparam int unsigned  TICK_W           = 4;

  // Decoded tick positions; every strobe leaves its flop one tick later
  localparam logic [3:0]   HALF_ALE_FIRST   = 4'h0;
  localparam logic [3:0]   HALF_ALE_LAST    = 4'h1;
  localparam logic [3:0]   HALF_ADDR_LAST   = 4'h2;
  localparam logic [3:0]   HALF_PROGRAM_READ_STROBE_N_FIRST  = 4'h3;
  localparam logic [3:0]   HALF_PROGRAM_READ_STROBE_N_LAST   = 4'h5;
  localparam logic [3:0]   CYCLE_LAST_TICK  = 4'hb;
  localparam logic [3:0]   HALF_START_TICK  = 4'h6;
  localparam logic [3:0]   FETCH_CAP_LO     = 4'h0;
  localparam logic [3:0]   FETCH_CAP_HI     = 4'h6;
  localparam logic [3:0]   XSTB_FIRST_TICK  = 4'hb;
  localparam logic [3:0]   XSTB_LAST_TICK   = 4'h4;
  localparam logic [3:0]   XDATA_FIRST_TICK = 4'h9;
  localparam logic [3:0]   XDATA_LAST_TICK  = 4'h5;
  localparam logic [3:0]   XREAD_CAP_TICK   = 4'h5;

  // Highest program address served from internal memory
  localparam logic [15:0]  INTERNAL_TOP     = 16'h1fff;

  // Reset values
  localparam logic [7:0]   PORT_RESET       = 8'hff;
  localparam logic [15:0]  ADDR_RESET       = 16'h0000;
  localparam logic [7:0]   BYTE_RESET       = 8'h00;

  typedef enum logic [1:0] {
    XBI_NORMAL = 2'b00,
    XBI_XMOVE1 = 2'b01,
    XBI_XMOVE2 = 2'b10
  } xbi_cycle_type;

endpackage : xbi_pkg

// ### hw/xbi_phase_counter.sv
`timescale 1ns/1ps
module xbi_phase_counter #(
  parameter int unsigned TICKS = xbi_pkg::TICKS_PER_CYCLE
) (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst,
  // Position within the machine cycle
  output      logic [xbi_pkg::TICK_W-1:0] tick_q
);

  localparam logic [xbi_pkg::TICK_W-1:0] LAST = xbi_pkg::TICK_W'(TICKS - 1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_q <= '0;
    end else if (tick_q == LAST) begin
      tick_q <= '0; // RQ19
    end else begin
      tick_q <= tick_q + xbi_pkg::TICK_W'(1);
    end
  end

endmodule : xbi_phase_counter

// ### hw/xbi_bus_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// (RQ1) Write byte spans the whole write strobe
// (RQ2) Read byte sampled while read strobe low
// (RQ3) External fetch when select low or above 1FFF
// (RQ4) High port carries address, latch unchanged
// (RQ5) High port: counter, pointer, or stored latch
// (RQ6) No program strobe for internal fetches
// (RQ7) Program strobe twice per cycle, except moves
// (RQ8) Data read cycle spans six oscillator periods
// (RQ9) Fetch cycle spans three oscillator periods
// (RQ10) Low address valid at latch strobe fall
// (RQ11) Latch strobe twice every machine cycle
// (RQ12) Latch strobe suppressed during data strobes
// (RQ13) Idle latch strobe at one sixth oscillator
// (RQ14) Low port drives both levels in bus mode
// (RQ15) High port address only for 16-bit accesses
// (RQ16) Merged read strobes need fetch-speed memory
// (RQ17) Every external access sets low latch ones
// (RQ18) Fetch 16-bit; moves pointer 16 or index 8
// (RQ19) Twelve ticks per cycle, strobes from count
module xbi_bus_sequencer (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // CPU fetch side
  input  wire logic [15:0] program_counter,
  output      logic [7:0]  fetch_data_q,
  output      logic        fetch_valid_q,
  output      logic        cycle_start_q,
  // CPU external data move side
  input  wire logic        move_req,
  input  wire logic        move_write,
  input  wire logic        move_use_pointer,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  indirect_index_register,
  input  wire logic [7:0]  move_wdata,
  output      logic [7:0]  move_rdata_q,
  output      logic        move_done_q,
  // Port latches held by the CPU
  input  wire logic [7:0]  high_port_latch,
  output      logic        low_port_latch_set_ones_q,
  // Pins
  input  wire logic        external_fetch_select_n,
  input  wire logic [7:0]  low_addr_data_port_in,
  output      logic [7:0]  low_addr_data_port_out_q,
  output      logic        low_addr_data_port_oe_q,
  output      logic [7:0]  high_addr_port_q,
  output      logic        addr_latch_strobe_q,
  output      logic        program_read_strobe_n_q,
  output      logic        data_read_strobe_n_q,
  output      logic        data_write_strobe_n_q
);

  logic [3:0]                 tick;
  logic [3:0]                 hpos;
  logic                       upper;
  xbi_pkg::xbi_cycle_type     cyc_q;
  logic                       sel_meta_q;
  logic                       sel_sync_q;
  logic [7:0]                 pin_meta_q;
  logic [7:0]                 pin_sync_q;
  logic                       ext_fetch;
  logic                       ext_q;
  logic                       addr_half;
  logic                       xfer_half;
  logic                       move_win;
  logic                       strobe_win;
  logic                       data_win;
  logic                       fetch_half;
  logic                       fetched_q;
  logic                       wr_q;
  logic                       ptr_q;
  logic [15:0]                addr_q;
  logic [7:0]                 wdata_q;

  xbi_phase_counter #(
    .TICKS (xbi_pkg::TICKS_PER_CYCLE)
  ) u_phase (
    .mclk   (mclk),
    .rst    (rst),
    .tick_q (tick)
  );

  // Pin inputs cross two flops before any decode
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_meta_q <= 1'b1;
      sel_sync_q <= 1'b1;
      pin_meta_q <= xbi_pkg::PORT_RESET;
      pin_sync_q <= xbi_pkg::PORT_RESET;
    end else begin
      sel_meta_q <= external_fetch_select_n;
      sel_sync_q <= sel_meta_q;
      pin_meta_q <= low_addr_data_port_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign upper = (tick >= xbi_pkg::HALF_START_TICK);
  assign hpos  = upper ? (tick - xbi_pkg::HALF_START_TICK) : tick;

  assign ext_fetch  = ~sel_sync_q | (program_counter > xbi_pkg::INTERNAL_TOP); // RQ3
  // Second half of the first move cycle carries the data address
  assign addr_half  = (cyc_q == xbi_pkg::XBI_XMOVE1) && upper;
  // First half of the second move cycle carries the data strobe
  assign xfer_half  = (cyc_q == xbi_pkg::XBI_XMOVE2) && !upper;
  assign move_win   = addr_half || xfer_half;
  assign fetch_half = ext_q && !move_win; // RQ6 RQ7
  assign strobe_win = ((cyc_q == xbi_pkg::XBI_XMOVE1) && (tick == xbi_pkg::XSTB_FIRST_TICK))
                   || (xfer_half && (tick <= xbi_pkg::XSTB_LAST_TICK)); // RQ8
  assign data_win   = ((cyc_q == xbi_pkg::XBI_XMOVE1) && (tick >= xbi_pkg::XDATA_FIRST_TICK))
                   || (xfer_half && (tick <= xbi_pkg::XDATA_LAST_TICK)); // RQ1

  // Fetch decision frozen for a whole half; a live switch would cut a strobe short
  always_ff @(posedge mclk) begin
    if (rst) begin
      ext_q <= 1'b0;
    end else if (hpos == xbi_pkg::HALF_PROGRAM_READ_STROBE_N_LAST) begin
      ext_q <= ext_fetch; // RQ3 RQ9
    end
  end

  // Machine cycle kind; a move takes two whole cycles
  always_ff @(posedge mclk) begin
    if (rst) begin
      cyc_q <= xbi_pkg::XBI_NORMAL;
      wr_q  <= 1'b0;
      ptr_q <= 1'b0;
      addr_q  <= xbi_pkg::ADDR_RESET;
      wdata_q <= xbi_pkg::BYTE_RESET;
    end else if (tick == xbi_pkg::CYCLE_LAST_TICK) begin
      unique case (cyc_q)
        xbi_pkg::XBI_NORMAL: begin
          if (move_req) begin
            cyc_q   <= xbi_pkg::XBI_XMOVE1;
            wr_q    <= move_write;
            ptr_q   <= move_use_pointer;
            addr_q  <= move_use_pointer ? data_pointer
                                        : {8'h00, indirect_index_register}; // RQ18
            wdata_q <= move_wdata;
          end
        end
        xbi_pkg::XBI_XMOVE1: cyc_q <= xbi_pkg::XBI_XMOVE2;
        xbi_pkg::XBI_XMOVE2: cyc_q <= xbi_pkg::XBI_NORMAL;
        default:             cyc_q <= xbi_pkg::XBI_NORMAL;
      endcase
    end
  end

  // Latch strobe: two per cycle, minus the one under a data strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_latch_strobe_q <= 1'b0;
      cycle_start_q       <= 1'b0;
    end else begin
      addr_latch_strobe_q <= (hpos <= xbi_pkg::HALF_ALE_LAST)
                          && (hpos >= xbi_pkg::HALF_ALE_FIRST) && !xfer_half; // RQ11 RQ12 RQ13
      cycle_start_q       <= (tick == xbi_pkg::CYCLE_LAST_TICK);
    end
  end

  // Program strobe low for three periods of each external fetch half
  always_ff @(posedge mclk) begin
    if (rst) begin
      program_read_strobe_n_q <= 1'b1;
      data_read_strobe_n_q    <= 1'b1;
      data_write_strobe_n_q   <= 1'b1;
    end else begin
      program_read_strobe_n_q <= !(fetch_half && (hpos >= xbi_pkg::HALF_PROGRAM_READ_STROBE_N_FIRST)
                                 && (hpos <= xbi_pkg::HALF_PROGRAM_READ_STROBE_N_LAST)); // RQ9 RQ7 RQ6
      data_read_strobe_n_q    <= !(strobe_win && !wr_q); // RQ8
      data_write_strobe_n_q   <= !(strobe_win && wr_q);  // RQ1
    end
  end

  // Low port: address, then write data; released for incoming bytes
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_addr_data_port_out_q <= xbi_pkg::PORT_RESET;
      low_addr_data_port_oe_q  <= 1'b0;
    end else if ((fetch_half || addr_half) && (hpos <= xbi_pkg::HALF_ADDR_LAST)) begin
      // Held one tick past the latch strobe fall so the latch sees it settled
      low_addr_data_port_out_q <= addr_half ? addr_q[7:0] : program_counter[7:0]; // RQ10
      low_addr_data_port_oe_q  <= 1'b1; // RQ14
    end else if (data_win && wr_q) begin
      low_addr_data_port_out_q <= wdata_q; // RQ1
      low_addr_data_port_oe_q  <= 1'b1;    // RQ14
    end else begin
      low_addr_data_port_out_q <= xbi_pkg::PORT_RESET;
      low_addr_data_port_oe_q  <= 1'b0;
    end
  end

  // High port never writes the latch; it only picks what to show
  always_ff @(posedge mclk) begin
    if (rst) begin
      high_addr_port_q <= xbi_pkg::PORT_RESET;
    end else if (move_win) begin
      high_addr_port_q <= ptr_q ? addr_q[15:8] : high_port_latch; // RQ5 RQ15 RQ18
    end else if (ext_fetch) begin
      high_addr_port_q <= program_counter[15:8]; // RQ4 RQ5
    end else begin
      high_addr_port_q <= high_port_latch; // RQ4
    end
  end

  // Each external access overwrites the low port latch with ones
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_port_latch_set_ones_q <= 1'b0;
    end else begin
      low_port_latch_set_ones_q <= (fetch_half || addr_half)
                                && (hpos == xbi_pkg::HALF_ALE_FIRST); // RQ17
    end
  end

  // Fetched byte: pin seen two ticks earlier, program strobe still low
  always_ff @(posedge mclk) begin
    if (rst) begin
      fetched_q     <= 1'b0;
      fetch_data_q  <= xbi_pkg::BYTE_RESET;
      fetch_valid_q <= 1'b0;
    end else begin
      if (hpos == xbi_pkg::HALF_PROGRAM_READ_STROBE_N_LAST) begin
        fetched_q <= fetch_half;
      end
      if (((tick == xbi_pkg::FETCH_CAP_LO) || (tick == xbi_pkg::FETCH_CAP_HI)) && fetched_q) begin
        fetch_data_q  <= pin_sync_q;
        fetch_valid_q <= 1'b1;
      end else begin
        fetch_valid_q <= 1'b0;
      end
    end
  end

  // Move completion; read byte taken before the read strobe rises
  always_ff @(posedge mclk) begin
    if (rst) begin
      move_rdata_q <= xbi_pkg::BYTE_RESET;
      move_done_q  <= 1'b0;
    end else if (xfer_half && (tick == xbi_pkg::XREAD_CAP_TICK)) begin
      if (!wr_q) begin
        move_rdata_q <= pin_sync_q; // RQ2
      end
      move_done_q <= 1'b1;
    end else begin
      move_done_q <= 1'b0;
    end
  end

endmodule : xbi_bus_sequencer

// ### testbench/xbi_ext_mem.sv
`timescale 1ns/1ps
module xbi_ext_mem (
  // Device strobes and pins
  input  wire logic       mclk,
  input  wire logic       ale,
  input  wire logic       oe,
  input  wire logic [7:0] ad_out,
  input  wire logic [7:0] a_hi,
  input  wire logic       prog_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  // Byte back to the device
  output      logic [7:0] ad_in
);
  logic [15:0] adr_q  = 16'h0000;
  logic [7:0]  last_q = 8'h00;
  logic [7:0]  mem [logic [15:0]];
  always @(negedge ale) adr_q = {a_hi, ad_out};
  always @(posedge wr_n) if (oe === 1'b1) mem[adr_q] = ad_out;
  // Released bus shows the inverse of the last byte, never a stale copy
  always @* begin
    if (!prog_n) ad_in = adr_q[7:0] ^ adr_q[15:8] ^ 8'h5a;
    else if (!rd_n) ad_in = mem.exists(adr_q) ? mem[adr_q] : 8'h00;
    else ad_in = ~last_q;
  end
  always @(posedge mclk) if (!(prog_n && rd_n)) last_q <= ad_in;
endmodule : xbi_ext_mem

// ### testbench/xbi_bus_props.sv
`timescale 1ns/1ps
module xbi_bus_props (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Pins and pulses
  input wire logic       addr_latch_strobe_q,
  input wire logic       program_read_strobe_n_q,
  input wire logic       data_read_strobe_n_q,
  input wire logic       data_write_strobe_n_q,
  input wire logic       low_addr_data_port_oe_q,
  input wire logic [7:0] low_addr_data_port_out_q,
  input wire logic       low_port_latch_set_ones_q,
  input wire logic       move_done_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic xs;
  assign xs = !data_read_strobe_n_q || !data_write_strobe_n_q;
  sequence s_ale_pulse;
    addr_latch_strobe_q[*2] ##1 !addr_latch_strobe_q;
  endsequence
  sequence s_prog_low;
    !program_read_strobe_n_q[*3] ##1 program_read_strobe_n_q;
  endsequence
  sequence s_read_low;
    (!data_read_strobe_n_q && !low_addr_data_port_oe_q)[*6] ##1
      (data_read_strobe_n_q && move_done_q);
  endsequence
  a_ale_width: assert property ($rose(addr_latch_strobe_q) |-> s_ale_pulse)
    else $error("ale width");
  a_ale_rate: assert property ($rose(addr_latch_strobe_q) |-> ##6 (addr_latch_strobe_q || xs))
    else $error("ale rate");
  a_ale_quiet: assert property (xs |-> !addr_latch_strobe_q)
    else $error("ale during strobe");
  a_prog_width: assert property ($fell(program_read_strobe_n_q) |-> s_prog_low)
    else $error("program strobe width");
  a_prog_ext: assert property ($fell(program_read_strobe_n_q) |->
    $past(addr_latch_strobe_q, 2) && $past(low_addr_data_port_oe_q))
    else $error("program strobe without address");
  a_prog_no_move: assert property (xs |-> program_read_strobe_n_q)
    else $error("program strobe in move");
  a_write_held: assert property ((!data_write_strobe_n_q || $rose(data_write_strobe_n_q)) |->
    low_addr_data_port_oe_q && $stable(low_addr_data_port_out_q))
    else $error("write data moved");
  a_read_span: assert property ($fell(data_read_strobe_n_q) |-> s_read_low)
    else $error("read cycle span");
  a_ones_addr: assert property ($rose(addr_latch_strobe_q) |->
    low_port_latch_set_ones_q == low_addr_data_port_oe_q)
    else $error("latch ones pulse");
endmodule : xbi_bus_props
bind xbi_bus_sequencer xbi_bus_props xbi_bus_props_inst (.mclk, .rst, .addr_latch_strobe_q,
  .program_read_strobe_n_q, .data_read_strobe_n_q, .data_write_strobe_n_q,
  .low_addr_data_port_oe_q, .low_addr_data_port_out_q, .low_port_latch_set_ones_q, .move_done_q);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic mclk = 0, rst = 1, move_req = 0, move_write = 0, move_use_pointer = 0, sel_n = 1;
  logic [15:0] pc = 16'h0000, dp = 16'h0000;
  logic [7:0]  idx = 8'h00, wd = 8'h00, hpl = 8'h00, pin, fdata, rdata, pout, hp;
  logic        fvalid, cstart, done, ones, oe, ale, program_read_strobe_n_n, rd_n, wr_n;
  logic [31:0] r;
  int          errors = 0, cmp_count = 0;
  always #2 mclk = ~mclk;
  xbi_bus_sequencer xbi_bus_sequencer_inst (.mclk, .rst, .program_counter(pc),
    .fetch_data_q(fdata), .fetch_valid_q(fvalid), .cycle_start_q(cstart), .move_req,
    .move_write, .move_use_pointer, .data_pointer(dp), .indirect_index_register(idx),
    .move_wdata(wd), .move_rdata_q(rdata), .move_done_q(done), .high_port_latch(hpl),
    .low_port_latch_set_ones_q(ones), .external_fetch_select_n(sel_n),
    .low_addr_data_port_in(pin), .low_addr_data_port_out_q(pout),
    .low_addr_data_port_oe_q(oe), .high_addr_port_q(hp), .addr_latch_strobe_q(ale),
    .program_read_strobe_n_q(program_read_strobe_n_n), .data_read_strobe_n_q(rd_n),
    .data_write_strobe_n_q(wr_n));
  xbi_ext_mem xbi_ext_mem_inst (.mclk, .ale, .oe, .ad_out(pout), .a_hi(hp),
    .prog_n(program_read_strobe_n_n), .rd_n, .wr_n, .ad_in(pin));
  function automatic logic [7:0] pf(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : pf
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // One settled machine cycle of fetches at a fixed address
  task automatic fetch(input logic [15:0] a, input logic s, input logic ext);
    int na;
    int np;
    logic pa;
    logic pp;
    na = 0;
    np = 0;
    pa = 0;
    pp = 1;
    @(posedge mclk);
    pc <= a;
    sel_n <= s;
    hpl <= 8'($urandom);
    repeat (24) @(posedge mclk);
    do begin
      @(posedge mclk);
      #1;
    end while (cstart !== 1'b1);
    repeat (12) begin
      @(posedge mclk);
      #1;
      if ((ale & ~pa) === 1'b1) na++;
      if ((ale & ~pa & ext) === 1'b1) chk(pout, a[7:0]);
      if ((~program_read_strobe_n_n & pp) === 1'b1) np++;
      if ((fvalid & ext) === 1'b1) chk(fdata, pf(a));
      chk(hp, ext ? a[15:8] : hpl);
      pa = ale;
      pp = program_read_strobe_n_n;
    end
    chk(8'(na), 8'h02);
    chk(8'(np), ext ? 8'h02 : 8'h00);
  endtask : fetch
  // Request stays up so a following call is taken at the end of the next normal cycle
  task automatic move(input logic w, input logic u, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    move_req <= 1;
    move_write <= w;
    move_use_pointer <= u;
    dp <= a;
    idx <= a[7:0];
    wd <= d;
    do begin
      @(posedge mclk);
      #1;
      if ((rd_n & wr_n) === 1'b0) chk(hp, u ? a[15:8] : hpl);
    end while (done !== 1'b1);
    if (!w) chk(rdata, d);
  endtask : move
  // Whole run is near 1000 cycles; limit allows many times that
  initial begin
    #200000;
    errors++;
    test_done;
  end
  initial begin
    r = $urandom(39084);
    repeat (10) @(posedge mclk);
    rst <= 0;
    fetch(16'h1fff, 1, 0);
    fetch(16'h2000, 1, 1);
    fetch(16'h0000, 0, 1);
    repeat (6) begin
      r = $urandom;
      fetch(r[15:0], r[16], !r[16] || r[15:0] > 16'h1fff);
    end
    repeat (8) begin
      r = $urandom;
      move(1, r[24], r[15:0], r[23:16]);
      move(0, r[24], r[15:0], r[23:16]);
    end
    @(posedge mclk);
    move_req <= 0;
    test_done;
  end
endmodule : tb_top
